/* File: src/status_pin_function_select.sv */
// status pin multiplexer, uart line inversion, suspend and wake logic
// assumes AXI4-Lite registers, uart core pulses synchronous to clk,
// and a config memory returning data one cycle after a sampled read
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module status_pin_function_select #(
	parameter int LED_STRETCH_CYCLES = status_pin_pkg::LED_STRETCH_CYCLES,
	parameter int WAKE_CYCLES = status_pin_pkg::WAKE_CYCLES,
	parameter logic [31:0] DEVICE_ID = 32'h0000_0A5A // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// AXI4-Lite register port
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// usb core side
	input wire logic usb_suspend,
	input wire logic usb_reset,
	input wire logic dedicated_charge_port,
	output logic device_suspend,
	output logic remote_wake_req,
	// uart core side
	input wire logic tx_char,
	input wire logic rx_char,
	input wire logic tx_pre_start,
	input wire logic tx_stop_end,
	input wire logic core_txd,
	input wire logic core_rts_b,
	input wire logic core_dtr_b,
	output status_pin_pkg::uart_in_t core_in,
	// device pins
	output status_pin_pkg::uart_out_t uart_data_pins,
	input wire status_pin_pkg::uart_in_t uart_in_pins,
	output status_pin_pkg::pin_t [3:0] configurable_status_pins,
	// config memory read port
	output logic [7:0] config_memory_addr,
	output logic config_memory_rd,
	input wire logic [31:0] config_memory_rdata
);

	localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

	// counters of zero length cannot time anything
	if (WAKE_CYCLES < 1 || LED_STRETCH_CYCLES < 1) begin : g_check
		$error("status_pin_function_select: counts must be at least 1");
	end

	typedef struct packed {
		status_pin_pkg::scan_state_t scan; // config memory walk
		logic [7:0] mem_addr; // config word being read
		logic mem_rd; // read strobe to the memory
		logic pulldown_en; // pull uart lines low in suspend
		logic wake_en; // remote wake allowed
		status_pin_pkg::pin_funcs_t pin_func; // one function per pin
		logic [7:0] invert; // per-line polarity swap
		logic [15:0] usb_version; // reported bcd version
		logic [7:0] max_power; // bus current in mA
		logic self_powered; // power source flag
		logic suspended; // effective suspend state
		logic charger; // charge port seen while suspended
		logic line_drv; // line driver enable
		logic wake_req; // resume request to the usb core
		logic [WAKE_W-1:0] wake_cnt; // cycles left on the request
		status_pin_pkg::pin_t [3:0] pins; // status pin drive
		status_pin_pkg::uart_out_t uart_out; // outgoing uart lines
		status_pin_pkg::uart_in_t core_in; // incoming lines, corrected
		logic awready;
		logic wready;
		logic aw_held; // write address captured
		logic w_held; // write data captured
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	// reset image: defaults stand until the scan replaces them
	function automatic state_t reset_state();
		state_t r;
		r = '0;
		r.scan = status_pin_pkg::SCAN_REQ0;
		r.pulldown_en = status_pin_pkg::PULLDOWN_RESET;
		r.wake_en = status_pin_pkg::WAKE_EN_RESET;
		r.pin_func = status_pin_pkg::PIN_FUNC_RESET;
		r.invert = status_pin_pkg::INVERT_RESET;
		r.usb_version = status_pin_pkg::USB_VERSION_RESET;
		r.max_power = status_pin_pkg::MAX_POWER_MA_RESET;
		r.self_powered = status_pin_pkg::SELF_POWERED_RESET;
		r.awready = 1'b1;
		r.wready = 1'b1;
		r.arready = 1'b1;
		for (int i = 0; i < 4; i++) begin
			r.pins[i].oe_b = 1'b1; // pins float until first update
		end
		return r;
	endfunction

	localparam state_t RESET_STATE = reset_state();

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[8*b +: 8] = data[8*b +: 8];
			end
		end
		return m;
	endfunction

	state_t s;
	state_t next_s;
	logic [1:0] act; // stretched activity: 1 receive, 0 transmit
	logic [1:0] act_trig; // character pulses feeding the one-shots

	assign act_trig = {rx_char, tx_char};

	// one stretcher per direction
	for (genvar k = 0; k < 2; k++) begin : g_led
		activity_one_shot #(
			.COUNT(LED_STRETCH_CYCLES)
		) u_one_shot (
			.clk(clk),
			.rst_b(rst_b),
			.ce(ce),
			.trigger(act_trig[k]),
			.active(act[k])
		);
	end

	// register image seen by a read
	function automatic logic [31:0] read_word(input state_t st,
		input logic [11:0] a, input logic [1:0] la);
		logic [31:0] r;
		r = '0;
		if (a == status_pin_pkg::ADDR_CTRL) begin
			r[status_pin_pkg::CTRL_PULLDOWN_BIT] = st.pulldown_en;
			r[status_pin_pkg::CTRL_WAKE_BIT] = st.wake_en;
		end else if (a == status_pin_pkg::ADDR_PIN_FUNC) begin
			r[15:0] = st.pin_func;
		end else if (a == status_pin_pkg::ADDR_INVERT) begin
			r[7:0] = st.invert;
		end else if (a == status_pin_pkg::ADDR_USB_CFG) begin
			r[status_pin_pkg::USBCFG_VERSION_LSB +: 16] = st.usb_version;
			r[status_pin_pkg::USBCFG_POWER_LSB +: 8] = st.max_power;
			r[status_pin_pkg::USBCFG_SELF_BIT] = st.self_powered;
		end else if (a == status_pin_pkg::ADDR_STATUS) begin
			r[status_pin_pkg::STAT_SUSPEND] = st.suspended;
			r[status_pin_pkg::STAT_CHARGER] = st.charger;
			r[status_pin_pkg::STAT_TX_ACT] = la[0];
			r[status_pin_pkg::STAT_RX_ACT] = la[1];
			r[status_pin_pkg::STAT_LINE_DRV] = st.line_drv;
			r[status_pin_pkg::STAT_SCAN_BUSY] =
				(st.scan != status_pin_pkg::SCAN_IDLE);
			r[status_pin_pkg::STAT_WAKE] = st.wake_req;
			r[status_pin_pkg::STAT_FULL_SPEED] = status_pin_pkg::FULL_SPEED;
			for (int i = 0; i < 4; i++) begin
				r[status_pin_pkg::STAT_PIN_OUT_LSB + i] = st.pins[i].out;
				r[status_pin_pkg::STAT_PIN_OE_LSB + i] = st.pins[i].oe_b;
			end
		end else if (a == status_pin_pkg::ADDR_ID) begin
			r = DEVICE_ID;
		end
		return r;
	endfunction

	// true for the six word addresses that exist
	function automatic logic mapped(input logic [11:0] a);
		return a == status_pin_pkg::ADDR_CTRL ||
			a == status_pin_pkg::ADDR_PIN_FUNC ||
			a == status_pin_pkg::ADDR_INVERT ||
			a == status_pin_pkg::ADDR_USB_CFG ||
			a == status_pin_pkg::ADDR_STATUS ||
			a == status_pin_pkg::ADDR_ID;
	endfunction

	// all next-state logic; later assignments take priority
	always_comb begin
		logic [11:0] wa;
		logic [11:0] ra;
		logic [31:0] cur;
		logic [31:0] mw;
		logic susp;
		logic ring_level;
		logic rescan;
		next_s = s;
		susp = usb_suspend || dedicated_charge_port;
		ring_level = uart_in_pins.wake_input_low ^
			s.invert[status_pin_pkg::INV_RING];
		wa = {s.aw_addr[11:2], 2'b00};
		ra = {s_axi_araddr[11:2], 2'b00};
		cur = read_word(s, wa, act);
		mw = merge(cur, s.w_data, s.w_strb);
		rescan = usb_reset;
		next_s.mem_rd = 1'b0;

		// write channel: address and data taken in either order
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_held = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// both halves held: commit and answer
		if (s.aw_held && s.w_held) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = status_pin_pkg::RESP_OKAY;
			if (wa == status_pin_pkg::ADDR_CTRL) begin
				next_s.pulldown_en = mw[status_pin_pkg::CTRL_PULLDOWN_BIT];
				next_s.wake_en = mw[status_pin_pkg::CTRL_WAKE_BIT];
				if (s.w_strb[0] && s.w_data[status_pin_pkg::CTRL_RESCAN_BIT]) begin
					rescan = 1'b1;
				end
			end else if (wa == status_pin_pkg::ADDR_PIN_FUNC) begin
				next_s.pin_func = status_pin_pkg::pin_funcs_t'(mw[15:0]);
			end else if (wa == status_pin_pkg::ADDR_INVERT) begin
				next_s.invert = mw[7:0];
			end else if (wa == status_pin_pkg::ADDR_USB_CFG) begin
				next_s.usb_version = mw[status_pin_pkg::USBCFG_VERSION_LSB +: 16];
				next_s.max_power = mw[status_pin_pkg::USBCFG_POWER_LSB +: 8];
				next_s.self_powered = mw[status_pin_pkg::USBCFG_SELF_BIT];
			end else if (!mapped(wa) || wa == status_pin_pkg::ADDR_STATUS ||
				wa == status_pin_pkg::ADDR_ID) begin
				next_s.bresp = status_pin_pkg::RESP_SLVERR; // read-only or hole
			end
		end

		// read channel: answer one cycle after the address is taken
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready && s_axi_arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = read_word(s, ra, act);
			next_s.rresp = mapped(ra) ? status_pin_pkg::RESP_OKAY :
				status_pin_pkg::RESP_SLVERR;
		end

		// config memory walk; it overrides a bus write in the same cycle
		case (s.scan)
			status_pin_pkg::SCAN_REQ0: begin
				next_s.mem_addr = status_pin_pkg::CFG_WORD_MAIN;
				next_s.mem_rd = 1'b1;
				next_s.scan = status_pin_pkg::SCAN_WAIT0;
			end
			status_pin_pkg::SCAN_WAIT0: begin
				next_s.scan = status_pin_pkg::SCAN_CAP0;
			end
			status_pin_pkg::SCAN_CAP0: begin
				next_s.pin_func =
					status_pin_pkg::pin_funcs_t'(config_memory_rdata[15:0]);
				next_s.pulldown_en =
					config_memory_rdata[status_pin_pkg::CFGW0_PULLDOWN_BIT];
				next_s.wake_en =
					config_memory_rdata[status_pin_pkg::CFGW0_WAKE_BIT];
				next_s.usb_version =
					config_memory_rdata[status_pin_pkg::CFGW0_VERSION_LSB +: 14]
					== 14'h0000 ? status_pin_pkg::USB_VERSION_RESET :
					{2'b00,
					config_memory_rdata[status_pin_pkg::CFGW0_VERSION_LSB +: 14]};
				next_s.mem_addr = status_pin_pkg::CFG_WORD_LINES;
				next_s.mem_rd = 1'b1;
				next_s.scan = status_pin_pkg::SCAN_WAIT1;
			end
			status_pin_pkg::SCAN_WAIT1: begin
				next_s.scan = status_pin_pkg::SCAN_CAP1;
			end
			status_pin_pkg::SCAN_CAP1: begin
				next_s.invert = config_memory_rdata[7:0];
				next_s.max_power =
					config_memory_rdata[status_pin_pkg::CFGW1_POWER_LSB +: 8];
				next_s.self_powered =
					config_memory_rdata[status_pin_pkg::CFGW1_SELF_BIT];
				next_s.scan = status_pin_pkg::SCAN_IDLE;
			end
			default: begin
				next_s.scan = status_pin_pkg::SCAN_IDLE;
			end
		endcase
		// a bus reset restarts the walk from the first word
		if (rescan) begin
			next_s.scan = status_pin_pkg::SCAN_REQ0;
		end

		// a charge port shorts the data lines, so the device suspends
		next_s.suspended = susp;
		next_s.charger = susp && dedicated_charge_port;

		// driver enable: set wins so back-to-back characters keep it on
		if (tx_pre_start) begin
			next_s.line_drv = 1'b1;
		end else if (tx_stop_end) begin
			next_s.line_drv = 1'b0;
		end

		// remote wake: request stands at most the wake time
		if (!s.suspended) begin
			next_s.wake_req = 1'b0;
			next_s.wake_cnt = '0;
		end else if (s.wake_req) begin
			if (s.wake_cnt == '0) begin
				next_s.wake_req = 1'b0;
			end else begin
				next_s.wake_cnt = s.wake_cnt - WAKE_W'(1);
			end
		end else if (s.wake_en && !ring_level) begin
			next_s.wake_req = 1'b1;
			next_s.wake_cnt = WAKE_W'(WAKE_CYCLES - 1);
		end

		// uart lines with optional inversion and suspend pull-down
		next_s.uart_out.txd = core_txd ^ s.invert[status_pin_pkg::INV_TXD];
		next_s.uart_out.rts_b = core_rts_b ^ s.invert[status_pin_pkg::INV_RTS];
		next_s.uart_out.dtr_b = core_dtr_b ^ s.invert[status_pin_pkg::INV_DTR];
		if (s.pulldown_en && s.suspended) begin
			next_s.uart_out = '0;
		end
		next_s.core_in.rxd = uart_in_pins.rxd ^
			s.invert[status_pin_pkg::INV_RXD];
		next_s.core_in.cts_b = uart_in_pins.cts_b ^
			s.invert[status_pin_pkg::INV_CTS];
		next_s.core_in.dsr_b = uart_in_pins.dsr_b ^
			s.invert[status_pin_pkg::INV_DSR];
		next_s.core_in.dcd_b = uart_in_pins.dcd_b ^
			s.invert[status_pin_pkg::INV_DCD];
		next_s.core_in.wake_input_low = ring_level;

		// status pin multiplexer; unknown codes leave the pin floating
		for (int i = 0; i < 4; i++) begin
			next_s.pins[i].out = 1'b0;
			next_s.pins[i].oe_b = 1'b0;
			case (s.pin_func[i])
				status_pin_pkg::FN_LINE_DRIVER: begin
					next_s.pins[i].out = s.line_drv;
				end
				status_pin_pkg::FN_RECEIVE_LED: begin
					next_s.pins[i].oe_b = !act[1];
				end
				status_pin_pkg::FN_TRANSMIT_LED: begin
					next_s.pins[i].oe_b = !act[0];
				end
				status_pin_pkg::FN_COMBINED_LED: begin
					next_s.pins[i].oe_b = !(act[0] || act[1]);
				end
				status_pin_pkg::FN_SUSPEND_LOW: begin
					next_s.pins[i].out = !s.suspended;
				end
				status_pin_pkg::FN_POWER_ENABLE_LOW: begin
					next_s.pins[i].out = s.suspended;
				end
				status_pin_pkg::FN_CHARGER_HIGH: begin
					next_s.pins[i].out = s.charger;
				end
				status_pin_pkg::FN_CHARGER_LOW: begin
					next_s.pins[i].out = !s.charger;
				end
				default: begin
					next_s.pins[i].oe_b = 1'b1;
				end
			endcase
		end

		// one transaction per channel in flight
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// single state register; ce low freezes block and bus alike
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= RESET_STATE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign device_suspend = s.suspended;
	assign remote_wake_req = s.wake_req;
	assign core_in = s.core_in;
	assign uart_data_pins = s.uart_out;
	assign configurable_status_pins = s.pins;
	assign config_memory_addr = s.mem_addr;
	assign config_memory_rd = s.mem_rd;

endmodule
`default_nettype wire

/* File: pkg/status_pin_pkg.sv */
// constants, types and register layout shared by the status pin logic
// assumes a 50 MHz clock and a synchronous one-word config memory port
package status_pin_pkg;

	// clock and time figures
	localparam int CLK_HZ = 50_000_000;
	localparam int LED_STRETCH_MS = 5;
	localparam int LED_STRETCH_CYCLES = (CLK_HZ / 1000) * LED_STRETCH_MS;
	localparam int WAKE_MS = 20;
	// longest time, so the division rounds down
	localparam int WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_MS;

	// register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_PIN_FUNC = 12'h004;
	localparam logic [11:0] ADDR_INVERT = 12'h008;
	localparam logic [11:0] ADDR_USB_CFG = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_ID = 12'h014;

	// control register fields
	localparam int CTRL_PULLDOWN_BIT = 0;
	localparam int CTRL_WAKE_BIT = 1;
	localparam int CTRL_RESCAN_BIT = 2;

	// inversion register fields, one bit per uart line
	localparam int INV_TXD = 0;
	localparam int INV_RXD = 1;
	localparam int INV_RTS = 2;
	localparam int INV_CTS = 3;
	localparam int INV_DTR = 4;
	localparam int INV_DSR = 5;
	localparam int INV_DCD = 6;
	localparam int INV_RING = 7;

	// usb config register fields
	localparam int USBCFG_VERSION_LSB = 0;
	localparam int USBCFG_POWER_LSB = 16;
	localparam int USBCFG_SELF_BIT = 24;

	// status register fields
	localparam int STAT_SUSPEND = 0;
	localparam int STAT_CHARGER = 1;
	localparam int STAT_TX_ACT = 2;
	localparam int STAT_RX_ACT = 3;
	localparam int STAT_LINE_DRV = 4;
	localparam int STAT_SCAN_BUSY = 5;
	localparam int STAT_WAKE = 6;
	localparam int STAT_FULL_SPEED = 7;
	localparam int STAT_PIN_OUT_LSB = 8;
	localparam int STAT_PIN_OE_LSB = 12;

	// config memory words and their layout
	localparam logic [7:0] CFG_WORD_MAIN = 8'h00;
	localparam logic [7:0] CFG_WORD_LINES = 8'h01;
	localparam int CFGW0_PULLDOWN_BIT = 16;
	localparam int CFGW0_WAKE_BIT = 17;
	localparam int CFGW0_VERSION_LSB = 18;
	localparam int CFGW1_POWER_LSB = 8;
	localparam int CFGW1_SELF_BIT = 16;

	// reset values
	localparam logic PULLDOWN_RESET = 1'b0;
	localparam logic WAKE_EN_RESET = 1'b1;
	localparam logic [7:0] INVERT_RESET = 8'h00;
	localparam logic [15:0] USB_VERSION_RESET = 16'h0200;
	localparam logic [7:0] MAX_POWER_MA_RESET = 8'h5A; // 90 mA
	localparam logic SELF_POWERED_RESET = 1'b0;
	localparam logic FULL_SPEED = 1'b1; // 12 Mb/s, never high speed

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// function of one status pin
	typedef enum logic [3:0] {
		FN_LINE_DRIVER,
		FN_RECEIVE_LED,
		FN_TRANSMIT_LED,
		FN_SUSPEND_LOW,
		FN_POWER_ENABLE_LOW,
		FN_COMBINED_LED,
		FN_CHARGER_HIGH,
		FN_CHARGER_LOW
	} pin_func_t;

	typedef pin_func_t [3:0] pin_funcs_t;

	localparam pin_funcs_t PIN_FUNC_RESET = '{FN_SUSPEND_LOW,
		FN_TRANSMIT_LED, FN_RECEIVE_LED, FN_LINE_DRIVER};

	// config memory scan sequence
	typedef enum logic [2:0] {
		SCAN_REQ0,
		SCAN_WAIT0,
		SCAN_CAP0,
		SCAN_WAIT1,
		SCAN_CAP1,
		SCAN_IDLE
	} scan_state_t;

	// one tri-state pin: oe_b low while driven
	typedef struct packed {
		logic out;
		logic oe_b;
	} pin_t;

	// uart lines leaving the device
	typedef struct packed {
		logic txd;
		logic rts_b;
		logic dtr_b;
	} uart_out_t;

	// uart lines entering the device
	typedef struct packed {
		logic rxd;
		logic cts_b;
		logic dsr_b;
		logic dcd_b;
		logic wake_input_low;
	} uart_in_t;

endpackage

/* File: src/activity_one_shot.sv */
// retriggerable one-shot that stretches activity pulses for an led
// assumes trigger is a one-cycle pulse per character, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module activity_one_shot #(
	parameter int COUNT = status_pin_pkg::LED_STRETCH_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic trigger,
	output logic active
);

	localparam int W = $clog2(COUNT + 1);

	// a zero-length stretch would make the led invisible
	if (COUNT < 1) begin : g_check
		$error("activity_one_shot: COUNT must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] count; // cycles left after this one
		logic active; // stretched indication
	} state_t;

	state_t s;
	state_t next_s;

	// retrigger restarts the full length, so a busy line stays lit
	always_comb begin
		next_s = s;
		if (trigger) begin
			next_s.count = W'(COUNT - 1);
			next_s.active = 1'b1;
		end else if (s.count != '0) begin
			next_s.count = s.count - W'(1);
		end else begin
			next_s.active = 1'b0;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign active = s.active;

endmodule
`default_nettype wire

/* File: dv/status_pin_checker_properties.sv */
// port assertions for the status pin block
// bound onto every status_pin_function_select instance
`timescale 1ns/1ps
`default_nettype none
module status_pin_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic usb_suspend,
	input wire logic usb_reset,
	input wire logic dedicated_charge_port,
	input wire logic device_suspend,
	input wire logic remote_wake_req,
	input wire logic config_memory_rd,
	input wire logic [7:0] config_memory_addr,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ce low freezes all state, so nothing is judged then
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !ce);
	property p_susp;
		$past(rst_b) && $past(ce) |-> device_suspend
			== $past(usb_suspend | dedicated_charge_port);
	endproperty
	a_susp: assert property (p_susp) else $error("suspend lag");
	property p_scan;
		usb_reset ##1 !usb_reset |-> ##1 (config_memory_rd
			&& config_memory_addr == 8'h00) ##1 !config_memory_rd
			##1 (config_memory_rd && config_memory_addr == 8'h01);
	endproperty
	a_scan: assert property (p_scan) else $error("scan order");
	property p_rdp;
		config_memory_rd |=> !config_memory_rd;
	endproperty
	a_rdp: assert property (p_rdp) else $error("read strobe");
	property p_rv;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rv: assert property (p_rv) else $error("read answer");
	property p_rdone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read end");
	property p_bdone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write end");
	// a resume request only ever comes out of suspend
	property p_wake;
		$rose(remote_wake_req) |-> $past(device_suspend);
	endproperty
	a_wake: assert property (p_wake) else $error("wake cause");
	property p_wdrop;
		!device_suspend |=> !remote_wake_req;
	endproperty
	a_wdrop: assert property (p_wdrop) else $error("wake drop");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property ($rose(remote_wake_req));
	cover property (usb_reset);
endmodule
bind status_pin_function_select status_pin_checker u_chk (.clk, .rst_b, .ce,
	.usb_suspend, .usb_reset, .dedicated_charge_port, .device_suspend,
	.remote_wake_req, .config_memory_rd, .config_memory_addr, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire

/* File: dv/config_memory_model.sv */
// config memory holding the shipped default settings
// answers one cycle after a sampled read strobe
`timescale 1ns/1ps
`default_nettype none
module config_memory_model (
	input wire logic clk,
	input wire logic [7:0] config_memory_addr,
	input wire logic config_memory_rd,
	output logic [31:0] config_memory_rdata
);
	initial config_memory_rdata = 32'h0;
	// data toggles when not read, so stale words never look valid
	always @(posedge clk) begin
		if (!config_memory_rd)
			config_memory_rdata <= ~config_memory_rdata;
		else if (config_memory_addr == 8'h00)
			config_memory_rdata <= 32'h0002_3210;
		else
			config_memory_rdata <= 32'h0000_5A00;
	end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// bench for the status pin block and its config memory
// drives the register port, usb state and uart core strobes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("mismatch t=%0t got %h exp %h", $time, g, e); \
	end \
end
module tb;
	logic clk, rst_b, ce, usb_suspend, usb_reset, dedicated_charge_port;
	logic device_suspend, remote_wake_req, tx_char, rx_char, tx_pre_start;
	logic tx_stop_end, core_txd, core_rts_b, core_dtr_b, config_memory_rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, config_memory_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] config_memory_addr;
	status_pin_pkg::uart_in_t core_in, uart_in_pins;
	status_pin_pkg::uart_out_t uart_data_pins;
	status_pin_pkg::pin_t [3:0] configurable_status_pins;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// short counts keep the run brief
	status_pin_function_select #(.LED_STRETCH_CYCLES(8), .WAKE_CYCLES(16))
		dut (.*);
	config_memory_model mem (.*);
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// hang guard, far above the roughly 130 cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'h0;
		ce = 1'h1;
		{usb_suspend, usb_reset, dedicated_charge_port} = 3'h0;
		{tx_char, rx_char, tx_pre_start, tx_stop_end} = 4'h0;
		{core_txd, core_rts_b, core_dtr_b} = 3'h7;
		uart_in_pins = '1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr} = 24'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		cyc(10);
		rd(12'h004);
		`CHK(rdat, 32'h0000_3210)
		rd(12'h000);
		`CHK(rdat, 32'h0000_0002)
		rd(12'h008);
		`CHK(rdat, 32'h0000_0000)
		rd(12'h00C);
		`CHK(rdat, 32'h005A_0200)
		rd(12'h010);
		`CHK(rdat[7:0], 8'h80)
		rd(12'h018);
		`CHK({resp, rdat}, 34'h2_0000_0000)
		wr(12'h014, 32'h0);
		`CHK(resp, 2'h2)
		`CHK(configurable_status_pins, 8'h94)
		@(posedge clk) tx_pre_start <= 1'h1;
		@(posedge clk) tx_pre_start <= 1'h0;
		cyc(1);
		`CHK(configurable_status_pins[0], 2'h2)
		@(posedge clk) tx_stop_end <= 1'h1;
		@(posedge clk) tx_stop_end <= 1'h0;
		cyc(1);
		`CHK(configurable_status_pins[0], 2'h0)
		$display("test defaults ends");
		@(posedge clk) tx_char <= 1'h1;
		@(posedge clk) tx_char <= 1'h0;
		cyc(1);
		`CHK(configurable_status_pins[2:1], 4'h1)
		cyc(6);
		`CHK(configurable_status_pins[2], 2'h0)
		cyc(2);
		`CHK(configurable_status_pins[2], 2'h1)
		wr(12'h004, 32'h0000_3215);
		`CHK(resp, 2'h0)
		@(posedge clk) rx_char <= 1'h1;
		@(posedge clk) rx_char <= 1'h0;
		cyc(1);
		`CHK(configurable_status_pins[1:0], 4'h0)
		$display("test leds ends");
		wr(12'h004, 32'h0000_3764);
		wr(12'h000, 32'h0000_0003);
		cyc(2);
		`CHK(configurable_status_pins, 8'hA0)
		@(posedge clk) usb_suspend <= 1'h1;
		@(posedge clk) uart_in_pins.wake_input_low <= 1'h0;
		cyc(3);
		`CHK(configurable_status_pins, 8'h22)
		`CHK(uart_data_pins, 3'h0)
		`CHK(remote_wake_req, 1'h1)
		@(posedge clk) dedicated_charge_port <= 1'h1;
		@(posedge clk) usb_suspend <= 1'h0;
		uart_in_pins.wake_input_low <= 1'h1;
		cyc(3);
		`CHK(configurable_status_pins, 8'h0A)
		`CHK(device_suspend, 1'h1)
		@(posedge clk) dedicated_charge_port <= 1'h0;
		cyc(3);
		`CHK(configurable_status_pins, 8'hA0)
		`CHK(uart_data_pins, 3'h7)
		`CHK(remote_wake_req, 1'h0)
		wr(12'h008, 32'h0000_0003);
		cyc(2);
		`CHK(uart_data_pins, 3'h3)
		`CHK(core_in, 5'h0F)
		$display("test suspend ends");
		@(posedge clk) usb_reset <= 1'h1;
		@(posedge clk) usb_reset <= 1'h0;
		cyc(8);
		rd(12'h004);
		`CHK(rdat, 32'h0000_3210)
		rd(12'h000);
		`CHK(rdat, 32'h0000_0002)
		wr(12'h004, 32'h0000_FFFF);
		`CHK(resp, 2'h0)
		cyc(1);
		`CHK(configurable_status_pins, 8'h55)
		wr(12'h000, 32'h0000_0004);
		cyc(8);
		rd(12'h004);
		`CHK(rdat, 32'h0000_3210)
		$display("test rescan ends");
		give_verdict();
	end
endmodule
`default_nettype wire
